// [rtl/wtc_top.sv]
// Overview of operation
// RULE_01: Expiry in a reset mode gives an internal reset pulse of one clock.
// RULE_02: The falling edge of that pulse starts the start-up delay timer.
// RULE_03: The counter advances on edges of the separate 128kHz oscillator.
// RULE_04: At the selected count the current mode's action is taken.
// RULE_05: Software restarts the counter before it reaches the time-out.
// RULE_06: Interrupt mode raises the interrupt and never resets the system.
// RULE_07: The interrupt request also serves as a wake-up event.
// RULE_08: System reset mode resets the system on expiry.
// RULE_09: Combined mode interrupts first, then a later expiry resets.
// RULE_10: The always-on fuse forces system reset mode.
// RULE_11: With the fuse, reset enable reads one, interrupt enable zero.
// RULE_12: Clearing reset enable or changing the select needs the sequence.
// RULE_13: Software opens the sequence writing change enable and reset enable.
// RULE_14: The new values are accepted only within four clocks after opening.
// RULE_15: Time-out spans about 16ms to about 8s.
// RULE_16: An enabled watchdog stays enabled across its own reset.
// RULE_17: Start-up code should clear the reset flag, then reset enable.
// RULE_18: Software keeps interrupts off during the change sequence.
// RULE_19: Software keeps the old select value when opening the sequence.
// RULE_20: Select value n gives 2048 shifted by n cycles, n up to 9.
// RULE_21: Expiry with interrupts sets the flag; vector or writing one clears.
// RULE_22: In combined mode the vector clears interrupt enable and flag.
// RULE_23: A set watchdog reset flag forces reset enable to one.
// RULE_24: Outside the window only setting reset enable is accepted.
// RULE_25: Restart and any system reset clear the counter.
`timescale 1ns/1ps
module wtc_top #(
  parameter int STARTUP_CYC = wtc_pkg::STARTUP_CYC
) (
  // APB slave.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // Oscillator and fuse.
  input  wire logic        osc_clk,
  input  wire logic        always_on_fuse,
  // Interrupt handshake.
  input  wire logic        irq_ack,
  output      logic        irq,
  // Reset outputs.
  output      logic        wdog_rst,
  output      logic        startup_busy
);

  function automatic wtc_pkg::wtc_reg_t reg_sel(input logic [11:0] a);
    if (a == wtc_pkg::CTRL_OFS) begin
      return wtc_pkg::REG_CTRL;
    end else if (a == wtc_pkg::CAUSE_OFS) begin
      return wtc_pkg::REG_CAUSE;
    end else if (a == wtc_pkg::RESTART_OFS) begin
      return wtc_pkg::REG_RESTART;
    end else begin
      return wtc_pkg::REG_NONE;
    end
  endfunction : reg_sel

  // Reserved select codes run at the longest legal period.
  function automatic logic [19:0] tout_last(input logic [3:0] s);
    logic [3:0]  e;
    logic [20:0] t;
    e = (s > wtc_pkg::SEL_MAX) ? wtc_pkg::SEL_MAX : s;
    t = wtc_pkg::BASE_CYC << e;
    return t[19:0] - 20'h00001; // [RULE_15] [RULE_20]
  endfunction : tout_last

  logic             osc_s1_r;
  logic             osc_s2_r;
  logic             osc_s3_r;
  logic             fuse_s1_r;
  logic             fuse_s2_r;
  logic [19:0]      cnt_r;
  logic [19:0]      cnt_nxt;
  logic [2:0]       win_r;
  logic [2:0]       win_nxt;
  logic             ie_r;
  logic             ie_nxt;
  logic             re_r;
  logic             re_nxt;
  logic             flag_r;
  logic             flag_nxt;
  logic [3:0]       sel_r;
  logic [3:0]       sel_nxt;
  logic             rstf_r;
  logic             rstf_nxt;
  logic             rst_r;
  logic             rst_nxt;
  logic             irq_r;
  logic             irq_nxt;
  logic [23:0]      dly_r;
  logic [23:0]      dly_nxt;
  logic [31:0]      rdata_r;
  logic [31:0]      rdata_nxt;
  wtc_pkg::wtc_reg_t rsel;
  logic             acc;
  logic             wr_ctrl;
  logic             wr_cause;
  logic             restart;
  logic             osc_rise;
  logic             expire;
  logic             win_open;
  logic             ie_eff;
  logic             re_eff;
  logic             prot_ok;

  default clocking pclk_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // The oscillator is slow and unrelated to pclk, so it is only ever
  // seen as a synchronised edge; a 100 MHz pclk samples it many times.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_s1_r  <= 1'b0;
      osc_s2_r  <= 1'b0;
      osc_s3_r  <= 1'b0;
      fuse_s1_r <= 1'b0;
      fuse_s2_r <= 1'b0;
    end else begin
      osc_s1_r  <= osc_clk;
      osc_s2_r  <= osc_s1_r;
      osc_s3_r  <= osc_s2_r;
      fuse_s1_r <= always_on_fuse;
      fuse_s2_r <= fuse_s1_r;
    end
  end

  assign rsel     = reg_sel(paddr);
  assign acc      = psel & penable;
  assign wr_ctrl  = acc & pwrite & (rsel == wtc_pkg::REG_CTRL);
  assign wr_cause = acc & pwrite & (rsel == wtc_pkg::REG_CAUSE);
  assign restart  = acc & pwrite & (rsel == wtc_pkg::REG_RESTART);
  assign osc_rise = osc_s2_r & ~osc_s3_r; // [RULE_03]
  assign expire   = osc_rise & ~restart & ~rst_r
                  & (cnt_r == tout_last(sel_r)); // [RULE_04] [RULE_20]
  assign win_open = (win_r != 3'h0); // [RULE_14]
  assign ie_eff   = ie_r & ~fuse_s2_r; // [RULE_11]
  assign re_eff   = re_r | rstf_r | fuse_s2_r; // [RULE_10] [RULE_23]
  assign prot_ok  = win_open & ~pwdata[wtc_pkg::CE_B]; // [RULE_12]

  always_comb begin
    cnt_nxt  = cnt_r;
    win_nxt  = win_r;
    ie_nxt   = ie_r;
    re_nxt   = re_r;
    flag_nxt = flag_r;
    sel_nxt  = sel_r;
    rstf_nxt = rstf_r;
    rst_nxt  = 1'b0;
    dly_nxt  = dly_r;
    if (restart || rst_r) begin
      cnt_nxt = 20'h00000; // [RULE_25]
    end else if (osc_rise) begin
      cnt_nxt = expire ? 20'h00000 : cnt_r + 20'h00001; // [RULE_03]
    end
    if (rst_r) begin
      dly_nxt = 24'(STARTUP_CYC); // [RULE_02]
    end else if (dly_r != 24'h000000) begin
      dly_nxt = dly_r - 24'h000001;
    end
    if (rst_r) begin
      // The system reset wipes the set-up but the reset flag keeps the
      // watchdog armed, so a runaway start-up is caught again.
      win_nxt  = 3'h0;
      ie_nxt   = 1'b0;
      flag_nxt = 1'b0;
      sel_nxt  = wtc_pkg::SEL_RST;
      re_nxt   = 1'b1; // [RULE_16]
    end else begin
      if (win_open) begin
        win_nxt = win_r - 3'h1;
      end
      if (irq_ack) begin
        flag_nxt = 1'b0; // [RULE_21]
        if (re_eff) begin
          ie_nxt = 1'b0; // [RULE_22]
        end
      end
      if (wr_ctrl) begin
        if (pwdata[wtc_pkg::CE_B] && pwdata[wtc_pkg::RE_B]) begin
          win_nxt = wtc_pkg::WIN_CYC; // [RULE_14]
        end else begin
          win_nxt = 3'h0;
        end
        ie_nxt = pwdata[wtc_pkg::IE_B] & ~fuse_s2_r; // [RULE_11]
        if (pwdata[wtc_pkg::FLAG_B]) begin
          flag_nxt = 1'b0; // [RULE_21]
        end
        if (pwdata[wtc_pkg::RE_B]) begin
          re_nxt = 1'b1; // [RULE_24]
        end else if (prot_ok) begin
          re_nxt = 1'b0; // [RULE_12]
        end
        if (prot_ok) begin
          sel_nxt = {pwdata[wtc_pkg::SEL3_B], pwdata[2:0]}; // [RULE_24]
        end
      end
      if (expire) begin
        if (ie_eff && (!re_eff || !flag_r)) begin
          flag_nxt = 1'b1; // [RULE_06] [RULE_09]
        end else if (re_eff) begin
          rst_nxt = 1'b1; // [RULE_01] [RULE_08]
        end
      end
    end
    if (wr_cause && !pwdata[wtc_pkg::RSTF_B]) begin
      rstf_nxt = 1'b0;
    end
    if (rst_nxt) begin
      rstf_nxt = 1'b1; // [RULE_23]
    end
    irq_nxt = flag_nxt & ie_nxt & ~fuse_s2_r; // [RULE_07]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r  <= 20'h00000;
      win_r  <= 3'h0;
      ie_r   <= 1'b0;
      re_r   <= 1'b0;
      flag_r <= 1'b0;
      sel_r  <= wtc_pkg::SEL_RST;
      rstf_r <= 1'b0;
      rst_r  <= 1'b0;
      irq_r  <= 1'b0;
      dly_r  <= 24'h000000;
    end else begin
      cnt_r  <= cnt_nxt;
      win_r  <= win_nxt;
      ie_r   <= ie_nxt;
      re_r   <= re_nxt;
      flag_r <= flag_nxt;
      sel_r  <= sel_nxt;
      rstf_r <= rstf_nxt;
      rst_r  <= rst_nxt;
      irq_r  <= irq_nxt;
      dly_r  <= dly_nxt;
    end
  end

  // Read data is captured in the setup cycle and held through access.
  always_comb begin
    rdata_nxt = rdata_r;
    if (psel && !penable) begin
      rdata_nxt = 32'h00000000;
      if (rsel == wtc_pkg::REG_CTRL) begin
        rdata_nxt[wtc_pkg::FLAG_B] = flag_r;
        rdata_nxt[wtc_pkg::IE_B]   = ie_eff; // [RULE_11]
        rdata_nxt[wtc_pkg::SEL3_B] = sel_r[3];
        rdata_nxt[wtc_pkg::CE_B]   = win_open;
        rdata_nxt[wtc_pkg::RE_B]   = re_eff; // [RULE_11]
        rdata_nxt[2:0]             = sel_r[2:0];
      end else if (rsel == wtc_pkg::REG_CAUSE) begin
        rdata_nxt[wtc_pkg::RSTF_B] = rstf_r;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign prdata       = rdata_r;
  assign pready       = 1'b1;
  assign pslverr      = acc & (rsel == wtc_pkg::REG_NONE);
  assign irq          = irq_r;
  assign wdog_rst     = rst_r;
  assign startup_busy = (dly_r != 24'h000000);

  a_rst_one_cycle: assert property (wdog_rst |=> !wdog_rst) // [RULE_01]
    else $error("reset pulse too long");
  a_delay_starts: assert property ( // [RULE_02]
    $fell(wdog_rst) |-> startup_busy ##1 startup_busy)
    else $error("delay timer not started");
  a_count_on_osc: assert property ( // [RULE_03]
    $changed(cnt_r) |-> $past(osc_rise | restart | rst_r))
    else $error("counter moved without an oscillator edge");
  a_reset_action: assert property ( // [RULE_08]
    expire && re_eff && (!ie_eff || flag_r) |=> wdog_rst && rstf_r)
    else $error("reset mode expiry without reset");
  a_irq_only: assert property ( // [RULE_06]
    expire && ie_eff && !re_eff && !wr_ctrl
    |=> irq && !wdog_rst ##1 !wdog_rst)
    else $error("interrupt mode misbehaved");
  // The irq register lags the fuse by one clock, so it is checked a cycle on.
  a_fuse_lock: assert property (fuse_s2_r |-> re_eff ##1 !irq) // [RULE_10]
    else $error("fuse not forcing");
  a_sel_locked: assert property ( // [RULE_24]
    wr_ctrl && !win_open && !rst_r |=> $stable(sel_r))
    else $error("select changed outside window");
  a_window_len: assert property ( // [RULE_14]
    wr_ctrl && pwdata[wtc_pkg::CE_B] && pwdata[wtc_pkg::RE_B] && !rst_r
    |=> win_r == wtc_pkg::WIN_CYC) else $error("window not opened");
  // A control write may close the window early, so only idle cycles count.
  a_window_count: assert property ( // [RULE_14]
    win_open && !wr_ctrl && !rst_r |=> win_r == $past(win_r) - 3'h1)
    else $error("window length");
  a_flag_forces: assert property ( // [RULE_23]
    rstf_r && psel && !penable && (rsel == wtc_pkg::REG_CTRL)
    |=> prdata[wtc_pkg::RE_B]) else $error("reset enable not forced");
  a_ack_combined: assert property ( // [RULE_22]
    irq_ack && re_eff && !expire && !wr_ctrl && !rst_r |=> !ie_r && !flag_r)
    else $error("vector did not disarm interrupt");
  a_restart_clr: assert property (restart |=> cnt_r == 20'h00000) // [RULE_25]
    else $error("restart ignored");

endmodule : wtc_top

// [rtl/wtc_pkg.sv]
package wtc_pkg;

  // Register byte offsets on the APB window.
  localparam logic [11:0] CTRL_OFS    = 12'h000;
  localparam logic [11:0] CAUSE_OFS   = 12'h004;
  localparam logic [11:0] RESTART_OFS = 12'h008;

  // Control register fields.
  localparam int FLAG_B = 7;
  localparam int IE_B   = 6;
  localparam int SEL3_B = 5;
  localparam int CE_B   = 4;
  localparam int RE_B   = 3;

  // Reset cause register field.
  localparam int RSTF_B = 3;

  // Reset values.
  localparam logic [3:0] SEL_RST = 4'h0;

  // Time-out selection: base count and the largest legal select value.
  localparam logic [20:0] BASE_CYC = 21'h000800;
  localparam logic [3:0]  SEL_MAX  = 4'h9;
  localparam int          TOUT_MIN_MS = 16;
  localparam int          TOUT_MAX_MS = 8000;
  localparam int          OSC_KHZ     = 128;

  // Timing on the system clock.
  localparam int         CLK_NS      = 10;
  localparam logic [2:0] WIN_CYC     = 3'h4;
  localparam int         STARTUP_US  = 65;
  localparam int         STARTUP_CYC = (STARTUP_US * 1000) / CLK_NS;

  typedef enum logic [1:0] {
    REG_CTRL    = 2'h0,
    REG_CAUSE   = 2'h1,
    REG_RESTART = 2'h2,
    REG_NONE    = 2'h3
  } wtc_reg_t;

endpackage : wtc_pkg

// [verif/test_watchdog_timer_ctrl.sv]
`timescale 1ns/1ps
module test_watchdog_timer_ctrl;
  typedef struct packed {
    logic        wr;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] e;
    logic        er;
  } wtc_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        irq, irq_ack, wdog_rst, startup_busy, osc_clk, fuse, er_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [1:0]  osc_q = 2'h0;
  int          err_total, tests_run, k, n;
  int          rst_cnt = 0;
  wtc_row_t    rows [12];

  wtc_top #(.STARTUP_CYC(8)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .osc_clk(osc_clk),
    .always_on_fuse(fuse), .irq_ack(irq_ack), .irq(irq),
    .wdog_rst(wdog_rst), .startup_busy(startup_busy)
  );

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // A fast oscillator keeps the shortest time-out within a short run.
  assign osc_clk = osc_q[1];
  always @(posedge pclk) osc_q <= osc_q + 2'h1;
  always @(posedge pclk) if (wdog_rst === 1'b1) rst_cnt <= rst_cnt + 1;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd_q = prdata;
    er_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h00000000);
    chk(rd_q, e);
  endtask : rd

  // Opens the change window and writes the new value inside it.
  task automatic seq(input logic [31:0] d);
    wr(wtc_pkg::CTRL_OFS, 32'h00000018);
    wr(wtc_pkg::CTRL_OFS, d);
  endtask : seq

  task automatic wait_irq;
    for (n = 0; n < 9000 && irq !== 1'b1; n++) @(posedge pclk);
  endtask : wait_irq

  task automatic results;
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  initial begin
    {psel, penable, pwrite, fuse, irq_ack, presetn} = 6'h00;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    {err_total, tests_run} = 0;
    rows = '{'{1'b1, wtc_pkg::CTRL_OFS, 32'h18, 32'h00, 1'b0},
             '{1'b1, wtc_pkg::CTRL_OFS, 32'h21, 32'h00, 1'b0},
             '{1'b0, wtc_pkg::CTRL_OFS, 32'h00, 32'h21, 1'b0},
             '{1'b1, wtc_pkg::CTRL_OFS, 32'h05, 32'h00, 1'b0},
             '{1'b0, wtc_pkg::CTRL_OFS, 32'h00, 32'h21, 1'b0},
             '{1'b1, wtc_pkg::CTRL_OFS, 32'h08, 32'h00, 1'b0},
             '{1'b0, wtc_pkg::CTRL_OFS, 32'h00, 32'h29, 1'b0},
             '{1'b1, wtc_pkg::CTRL_OFS, 32'h00, 32'h00, 1'b0},
             '{1'b0, wtc_pkg::CTRL_OFS, 32'h00, 32'h29, 1'b0},
             '{1'b1, 12'h00C, 32'h55, 32'h00, 1'b1},
             '{1'b0, 12'h00C, 32'h00, 32'h00, 1'b1},
             '{1'b1, wtc_pkg::RESTART_OFS, 32'h01, 32'h00, 1'b0}};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({29'h0, irq, wdog_rst, startup_busy}, 32'h0);
    apb(1'b0, wtc_pkg::CTRL_OFS, 32'h0);
    chk(rd_q, 32'h00);
    rd(wtc_pkg::CAUSE_OFS, 32'h00);
    foreach (rows[i]) begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk(rd_q, rows[i].e);
      chk({31'h0, er_q}, {31'h0, rows[i].er});
    end
    wr(wtc_pkg::CTRL_OFS, 32'h18);
    repeat (6) @(posedge pclk);
    wr(wtc_pkg::CTRL_OFS, 32'h00);
    rd(wtc_pkg::CTRL_OFS, 32'h29);
    seq(32'h00);
    fuse <= 1'b1;
    repeat (3) @(posedge pclk);
    wr(wtc_pkg::CTRL_OFS, 32'h40);
    rd(wtc_pkg::CTRL_OFS, 32'h08);
    seq(32'h00);
    rd(wtc_pkg::CTRL_OFS, 32'h08);
    fuse <= 1'b0;
    repeat (3) @(posedge pclk);
    seq(32'h00);
    rd(wtc_pkg::CTRL_OFS, 32'h00);
    wr(wtc_pkg::CTRL_OFS, 32'h40);
    k = rst_cnt;
    repeat (12) begin
      wr(wtc_pkg::RESTART_OFS, 32'h1);
      repeat (1000) @(posedge pclk);
      chk({31'h0, irq}, 32'h0);
    end
    wait_irq();
    chk({31'h0, irq}, 32'h1);
    // 2048 edges of a four-clock oscillator, less the 1000 already waited.
    chk({31'h0, n > 7000 && n < 7400}, 32'h1);
    rd(wtc_pkg::CTRL_OFS, 32'hC0);
    wr(wtc_pkg::CTRL_OFS, 32'hC0);
    rd(wtc_pkg::CTRL_OFS, 32'h40);
    chk(rst_cnt, k);
    wr(wtc_pkg::RESTART_OFS, 32'h1);
    wr(wtc_pkg::CTRL_OFS, 32'h48);
    wait_irq();
    chk({31'h0, irq}, 32'h1);
    irq_ack <= 1'b1;
    @(posedge pclk);
    irq_ack <= 1'b0;
    repeat (2) @(posedge pclk);
    rd(wtc_pkg::CTRL_OFS, 32'h08);
    for (n = 0; n < 9000 && wdog_rst !== 1'b1; n++) @(posedge pclk);
    chk({31'h0, wdog_rst}, 32'h1);
    @(posedge pclk);
    chk({30'h0, wdog_rst, startup_busy}, 32'h1);
    repeat (7) @(posedge pclk);
    chk({31'h0, startup_busy}, 32'h1);
    @(posedge pclk);
    chk({31'h0, startup_busy}, 32'h0);
    rd(wtc_pkg::CAUSE_OFS, 32'h08);
    seq(32'h00);
    rd(wtc_pkg::CTRL_OFS, 32'h08);
    wr(wtc_pkg::CAUSE_OFS, 32'h0);
    seq(32'h00);
    rd(wtc_pkg::CTRL_OFS, 32'h00);
    chk(rst_cnt, k + 1);
    results();
  end

  // The whole sequence needs about 36000 cycles.
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    results();
  end
endmodule : test_watchdog_timer_ctrl
